// ===== lpdls_pkg.sv
// package with register map, field positions, codes and types of the lcd pin drive block
package lpdls_pkg;
  localparam int LPDLS_NPINS = 8;
  localparam logic [7:0] LPDLS_OFF_BIAS = 8'h00;
  localparam logic [7:0] LPDLS_OFF_DRV = 8'h04;
  localparam logic [7:0] LPDLS_OFF_ROLE = 8'h08;
  localparam logic [7:0] LPDLS_OFF_DATA = 8'h0C;
  localparam logic [7:0] LPDLS_OFF_TIME = 8'h10;
  localparam logic [7:0] LPDLS_OFF_STAT = 8'h14;
  localparam logic [7:0] LPDLS_OFF_DISP = 8'h18;
  localparam int LPDLS_DRV_MODE0_BIT = 1;
  localparam int LPDLS_DRV_BYPASS_BIT = 3;
  localparam int LPDLS_DRV_ENABLE_BIT = 0;
  localparam int LPDLS_DRV_LOWMIX_BIT = 2;
  localparam logic [1:0] LPDLS_BIAS_RST = 2'h0;
  localparam logic [31:0] LPDLS_DRV_RST = 32'h0000_0000;
  localparam logic [31:0] LPDLS_TIME_RST = 32'h0010_0040;
  localparam logic [15:0] LPDLS_DIV_RST = 16'h0063;
  // bias selection codes
  localparam logic [1:0] LPDLS_BIAS_THIRD = 2'h0;
  localparam logic [1:0] LPDLS_BIAS_QUARTER = 2'h1;
  localparam logic [1:0] LPDLS_BIAS_FIFTH = 2'h2;
  localparam logic [1:0] LPDLS_BIAS_RSVD = 2'h3;
  // high upper mode bits, low upper mode bits
  localparam logic [1:0] LPDLS_MODE_HI_UP = 2'h0;
  localparam logic [1:0] LPDLS_MODE_LO_UP = 2'h3;

  typedef enum {LPDLS_SEL_GND, LPDLS_SEL_V0, LPDLS_SEL_V1, LPDLS_SEL_V2, LPDLS_SEL_V3,
    LPDLS_SEL_V4} lpdls_level_e;

  typedef enum {LPDLS_CFG_MUX16_FIFTH, LPDLS_CFG_MUX8_QUARTER,
    LPDLS_CFG_MUX4_THIRD} lpdls_cfg_e;

  typedef enum {LPDLS_STR_1X, LPDLS_STR_2X, LPDLS_STR_4X, LPDLS_STR_0P1X,
    LPDLS_STR_0P2X} lpdls_strength_e;

  typedef struct packed {
    logic [2:0] mode;
    logic frame_phase;
    logic drive;
    logic latch;
  } lpdls_ctrl_s;

  typedef struct packed {
    logic [2:0] level;
    logic buf_en;
    logic bypass;
  } lpdls_pin_s;
endpackage : lpdls_pkg

// ===== lpdls_pin_driver.sv
// one lcd pin driver: role mux, four-way level select, buffer gating and strength decode
`timescale 1ns/1ps
module lpdls_pin_driver
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic com_role,
  input wire logic port_bit,
  input wire lpdls_pkg::lpdls_ctrl_s ctrl,
  input wire logic bypass_en,
  output lpdls_pkg::lpdls_pin_s pin,
  output logic [2:0] seg_strength,
  output logic [2:0] com_strength,
  output logic disp_data
);
  import lpdls_pkg::*;

  logic disp_reg;
  lpdls_pin_s pin_reg;
  lpdls_level_e level;
  lpdls_strength_e seg_str;
  lpdls_strength_e com_str;
  lpdls_pin_s pin_next;

  // display bit is sampled only on the latch strobe, so dma writes mid-refresh cannot tear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      disp_reg <= 1'b0;
    else if (ctrl.latch)
      disp_reg <= port_bit;
  end

  always_comb
  begin
    level = LPDLS_SEL_GND;
    case ({com_role, disp_reg, ctrl.frame_phase})
      3'b000: level = LPDLS_SEL_V3;
      3'b001: level = LPDLS_SEL_V2;
      3'b010: level = LPDLS_SEL_GND;
      3'b011: level = LPDLS_SEL_V0;
      3'b100: level = LPDLS_SEL_V4;
      3'b101: level = LPDLS_SEL_V1;
      3'b110: level = LPDLS_SEL_V0;
      3'b111: level = LPDLS_SEL_GND;
      default: level = LPDLS_SEL_GND;
    endcase
  end

  always_comb
  begin
    seg_str = LPDLS_STR_1X;
    com_str = LPDLS_STR_1X;
    case (ctrl.mode)
      3'b000:
      begin
        seg_str = LPDLS_STR_1X;
        com_str = LPDLS_STR_1X;
      end
      3'b001:
      begin
        seg_str = LPDLS_STR_1X;
        com_str = LPDLS_STR_2X;
      end
      3'b010:
      begin
        seg_str = LPDLS_STR_1X;
        com_str = LPDLS_STR_4X;
      end
      3'b011:
      begin
        seg_str = LPDLS_STR_2X;
        com_str = LPDLS_STR_2X;
      end
      3'b100:
      begin
        seg_str = LPDLS_STR_2X;
        com_str = LPDLS_STR_4X;
      end
      3'b101:
      begin
        seg_str = LPDLS_STR_4X;
        com_str = LPDLS_STR_4X;
      end
      3'b110:
      begin
        seg_str = LPDLS_STR_0P1X;
        com_str = LPDLS_STR_0P1X;
      end
      default:
      begin
        seg_str = LPDLS_STR_0P2X;
        com_str = LPDLS_STR_0P2X;
      end
    endcase
  end

  always_comb
  begin
    pin_next.level = 3'(level);
    pin_next.buf_en = ctrl.drive;
    pin_next.bypass = !ctrl.drive && bypass_en;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_reg <= '0;
      seg_strength <= 3'h0;
      com_strength <= 3'h0;
    end
    else
    begin
      pin_reg <= pin_next;
      seg_strength <= 3'(seg_str);
      com_strength <= 3'(com_str);
    end
  end

  assign pin = pin_reg;
  assign disp_data = disp_reg;
endmodule : lpdls_pin_driver

// ===== lpdls_top.sv
// lcd pin drive top: apb registers, refresh controller and the per-pin drivers
//
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/1ps
module lpdls_top
#(
  parameter int NPINS = lpdls_pkg::LPDLS_NPINS
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [NPINS-1:0] pin_buf_en,
  output logic [NPINS-1:0] pin_bypass,
  output logic [3*NPINS-1:0] pin_level,
  output logic [3*NPINS-1:0] pin_seg_strength,
  output logic [3*NPINS-1:0] pin_com_strength,
  output logic [1:0] bias_select,
  output logic [1:0] bias_config,
  output logic dma_req,
  output logic frame_phase
);
  import lpdls_pkg::*;

  logic [1:0] bias_reg;
  logic [31:0] drv_reg;
  logic [NPINS-1:0] role_reg;
  logic [NPINS-1:0] data_reg;
  logic [31:0] time_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [15:0] div_cnt_reg;
  logic tick;
  logic [15:0] phase_cnt_reg;
  logic frame_reg;
  logic drive_reg;
  logic [1:0] mode_up_reg;
  logic latch_reg;
  logic dma_reg;
  logic [1:0] bias_cfg_reg;
  logic [NPINS-1:0] disp_bits;
  lpdls_ctrl_s ctrl;

  wire setup = psel && !penable;
  // the access edge is the one at which the master sees pready high
  wire access = psel && penable && pready_reg;
  // writes land at the access edge, so a request dropped after setup changes nothing
  wire wr_go = access && pwrite;
  wire [7:0] addr = paddr[7:0];
  wire addr_ok = (paddr[31:8] == 24'h0) && (addr[1:0] == 2'h0) &&
    (addr <= LPDLS_OFF_DISP);
  wire ctl_en = drv_reg[LPDLS_DRV_ENABLE_BIT];
  wire mix_low = drv_reg[LPDLS_DRV_LOWMIX_BIT];
  wire bypass_en = drv_reg[LPDLS_DRV_BYPASS_BIT];
  wire [15:0] period = time_reg[15:0];
  wire [15:0] high_time = time_reg[31:16];
  wire [15:0] div_limit = drv_reg[31:16];
  wire period_end = tick && (phase_cnt_reg >= period);
  wire in_high = phase_cnt_reg < high_time;

  // software writes take effect at the access edge, together with pready
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bias_reg <= LPDLS_BIAS_RST;
      drv_reg <= LPDLS_DRV_RST;
      role_reg <= '0;
      data_reg <= '0;
      time_reg <= LPDLS_TIME_RST;
    end
    else if (wr_go && addr_ok)
    begin
      case (addr)
        LPDLS_OFF_BIAS: bias_reg <= pwdata[1:0];
        LPDLS_OFF_DRV: drv_reg <= pwdata;
        LPDLS_OFF_ROLE: role_reg <= pwdata[NPINS-1:0];
        LPDLS_OFF_DATA: data_reg <= pwdata[NPINS-1:0];
        LPDLS_OFF_TIME: time_reg <= pwdata;
        default: ;
      endcase
    end
  end

  wire sel_bias = (addr == LPDLS_OFF_BIAS);
  wire sel_drv = (addr == LPDLS_OFF_DRV);
  wire sel_role = (addr == LPDLS_OFF_ROLE);
  wire sel_data = (addr == LPDLS_OFF_DATA);
  wire sel_time = (addr == LPDLS_OFF_TIME);
  wire sel_stat = (addr == LPDLS_OFF_STAT);
  wire sel_disp = (addr == LPDLS_OFF_DISP);
  // status word: phase count, bias decode, upper mode bits, drive and frame
  wire [31:0] stat_word = {phase_cnt_reg, 8'h0, 2'h0, bias_cfg_reg,
    mode_up_reg, drive_reg, frame_reg};
  wire [31:0] rd_mux =
    sel_bias ? {30'h0, bias_reg} :
    sel_drv ? drv_reg :
    sel_role ? {{(32-NPINS){1'b0}}, role_reg} :
    sel_data ? {{(32-NPINS){1'b0}}, data_reg} :
    sel_time ? time_reg :
    sel_stat ? stat_word :
    sel_disp ? {{(32-NPINS){1'b0}}, disp_bits} : 32'h0;

  // one wait-free access phase: pready rises in the cycle after setup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0;
    end
    else
    begin
      pready_reg <= setup;
      pslverr_reg <= setup && !addr_ok;
      if (setup)
        prdata_reg <= (addr_ok && !pwrite) ? rd_mux : 32'h0;
    end
  end

  // controller clock as an enable pulse; software picks the divide to suit the refresh rate
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_cnt_reg <= 16'h0;
    else if (!ctl_en || tick)
      div_cnt_reg <= 16'h0;
    else
      div_cnt_reg <= div_cnt_reg + 16'h1;
  end
  assign tick = ctl_en && (div_cnt_reg >= div_limit);

  // refresh period counter; frame, drive and mode move on the tick, but clearing enable resets drive and mode at once
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase_cnt_reg <= 16'h0;
      frame_reg <= 1'b0;
      drive_reg <= 1'b0;
      mode_up_reg <= LPDLS_MODE_HI_UP;
    end
    else if (!ctl_en)
    begin
      phase_cnt_reg <= 16'h0;
      drive_reg <= 1'b0;
      mode_up_reg <= LPDLS_MODE_HI_UP;
    end
    else if (tick)
    begin
      phase_cnt_reg <= period_end ? 16'h0 : phase_cnt_reg + 16'h1;
      if (period_end)
        frame_reg <= !frame_reg;
      // mixed mode holds drive high and swaps strength instead
      drive_reg <= mix_low ? 1'b1 : in_high;
      mode_up_reg <= (mix_low && !in_high) ? LPDLS_MODE_LO_UP : LPDLS_MODE_HI_UP;
    end
  end

  // latch strobe and dma request fire once as each refresh begins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      latch_reg <= 1'b0;
      dma_reg <= 1'b0;
    end
    else
    begin
      latch_reg <= period_end;
      dma_reg <= period_end;
    end
  end

  // the reserved code folds onto the sixteen-way fifth-bias setting
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      bias_cfg_reg <= 2'(LPDLS_CFG_MUX4_THIRD);
    else
    begin
      case (bias_reg)
        LPDLS_BIAS_FIFTH: bias_cfg_reg <= 2'(LPDLS_CFG_MUX16_FIFTH);
        LPDLS_BIAS_QUARTER: bias_cfg_reg <= 2'(LPDLS_CFG_MUX8_QUARTER);
        LPDLS_BIAS_THIRD: bias_cfg_reg <= 2'(LPDLS_CFG_MUX4_THIRD);
        LPDLS_BIAS_RSVD: bias_cfg_reg <= 2'(LPDLS_CFG_MUX16_FIFTH);
        default: bias_cfg_reg <= 2'(LPDLS_CFG_MUX16_FIFTH);
      endcase
    end
  end

  always_comb
  begin
    ctrl.mode = {mode_up_reg, drv_reg[LPDLS_DRV_MODE0_BIT]};
    ctrl.frame_phase = frame_reg;
    ctrl.drive = drive_reg;
    ctrl.latch = latch_reg;
  end

  genvar gi;
  generate
    for (gi = 0; gi < NPINS; gi++)
    begin : g_pin
      lpdls_pin_s pin_w;
      lpdls_pin_driver u_drv
      (
        .pclk(pclk),
        .presetn(presetn),
        .com_role(role_reg[gi]),
        .port_bit(data_reg[gi]),
        .ctrl(ctrl),
        .bypass_en(bypass_en),
        .pin(pin_w),
        .seg_strength(pin_seg_strength[3*gi +: 3]),
        .com_strength(pin_com_strength[3*gi +: 3]),
        .disp_data(disp_bits[gi])
      );
      assign pin_buf_en[gi] = pin_w.buf_en;
      assign pin_bypass[gi] = pin_w.bypass;
      assign pin_level[3*gi +: 3] = pin_w.level;
    end
  endgenerate

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign bias_select = bias_reg;
  assign bias_config = bias_cfg_reg;
  assign dma_req = dma_reg;
  assign frame_phase = frame_reg;
endmodule : lpdls_top

// ===== lpdls_top_sva.sv
// port-level checker for the lcd pin drive top
`timescale 1ns/1ps
module lpdls_top_chk
#(
  parameter int NPINS = 8
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [NPINS-1:0] pin_buf_en,
  input wire logic [NPINS-1:0] pin_bypass,
  input wire logic [3*NPINS-1:0] pin_seg_strength,
  input wire logic [3*NPINS-1:0] pin_com_strength,
  input wire logic [1:0] bias_select,
  input wire logic [1:0] bias_config,
  input wire logic dma_req,
  input wire logic frame_phase
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // two samples so the registered decode has caught up
  sequence s_sel(logic [1:0] c);
    (bias_select == c) [*2];
  endsequence
  property p_b00; s_sel(2'h0) |-> bias_config == 2'h2; endproperty
  property p_b01; s_sel(2'h1) |-> bias_config == 2'h1; endproperty
  property p_b10; s_sel(2'h2) |-> bias_config == 2'h0; endproperty
  property p_b11; s_sel(2'h3) |-> bias_config == 2'h0; endproperty
  property p_buf; (pin_buf_en & pin_bypass) == '0; endproperty
  property p_dma; $changed(frame_phase) |-> dma_req; endproperty
  property p_s01; pin_seg_strength[2:0] == 3'h3 |-> pin_com_strength[2:0] == 3'h3; endproperty
  property p_s02; pin_seg_strength[2:0] == 3'h4 |-> pin_com_strength[2:0] == 3'h4; endproperty
  property p_s1x;
    pin_seg_strength[2:0] == 3'h0 |-> pin_com_strength[2:0] inside {3'h0, 3'h1, 3'h2};
  endproperty
  a_b00: assert property (p_b00) else $error("bias 00 decode wrong");
  a_b01: assert property (p_b01) else $error("bias 01 decode wrong");
  a_b10: assert property (p_b10) else $error("bias 10 decode wrong");
  a_b11: assert property (p_b11) else $error("bias 11 decode wrong");
  a_buf: assert property (p_buf) else $error("buffer and bypass both on");
  a_dma: assert property (p_dma) else $error("no dma request after frame");
  a_s01: assert property (p_s01) else $error("low drive 0.1x pair wrong");
  a_s02: assert property (p_s02) else $error("low drive 0.2x pair wrong");
  a_s1x: assert property (p_s1x) else $error("high drive 1x pair wrong");
endmodule : lpdls_top_chk

bind lpdls_top lpdls_top_chk #(.NPINS(NPINS)) u_chk
(
  .pclk(pclk),
  .presetn(presetn),
  .pin_buf_en(pin_buf_en),
  .pin_bypass(pin_bypass),
  .pin_seg_strength(pin_seg_strength),
  .pin_com_strength(pin_com_strength),
  .bias_select(bias_select),
  .bias_config(bias_config),
  .dma_req(dma_req),
  .frame_phase(frame_phase)
);

// ===== lpdls_glass_model.sv
// lcd glass model: level seen on each electrode
`timescale 1ns/1ps
module lpdls_glass_model
#(
  parameter int NPINS = 8
)
(
  input wire logic pclk,
  input wire logic [NPINS-1:0] pin_buf_en,
  input wire logic [NPINS-1:0] pin_bypass,
  input wire logic [3*NPINS-1:0] pin_level,
  output logic [3*NPINS-1:0] elec_level,
  output logic [NPINS-1:0] elec_float
);
  logic [3*NPINS-1:0] last_reg;
  logic [NPINS-1:0] held;
  // a floating electrode drifts every cycle so a stale level never matches
  always_comb
  begin
    for (int i = 0; i < NPINS; i++)
    begin
      held[i] = pin_buf_en[i] | pin_bypass[i];
      elec_level[3*i+:3] = held[i] ? pin_level[3*i+:3] : ~last_reg[3*i+:3];
    end
  end
  // an undriven pin just floats, as with the high-z reset drive mode left alone
  assign elec_float = ~held;
  always_ff @(posedge pclk) last_reg <= elec_level;
endmodule : lpdls_glass_model

// ===== lcd_pin_drive_level_select_tb_top.sv
// self-checking bench for the lcd pin drive top
`timescale 1ns/1ps
module lcd_pin_drive_level_select_tb_top;
  import lpdls_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] pin_buf_en;
  logic [7:0] pin_bypass;
  logic [23:0] pin_level;
  logic [23:0] seg_s;
  logic [23:0] com_s;
  logic [1:0] bias_select;
  logic [1:0] bias_config;
  logic dma_req;
  logic frame_phase;
  logic [23:0] elec_level;
  logic [7:0] elec_float;
  logic [31:0] rd;
  logic er;
  int err_total = 0;
  int checks = 0;
  lpdls_top #(.NPINS(8)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_buf_en(pin_buf_en), .pin_bypass(pin_bypass),
    .pin_level(pin_level), .pin_seg_strength(seg_s), .pin_com_strength(com_s),
    .bias_select(bias_select), .bias_config(bias_config), .dma_req(dma_req),
    .frame_phase(frame_phase));
  lpdls_glass_model #(.NPINS(8)) u_glass (.pclk(pclk), .pin_buf_en(pin_buf_en),
    .pin_bypass(pin_bypass), .pin_level(pin_level), .elec_level(elec_level),
    .elec_float(elec_float));
  initial forever #10 pclk = ~pclk;
  task end_sim;
    $display("Mismatches %0d, comparisons %0d", err_total, checks);
    if (err_total == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_sim
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 20)
    begin
      err_total++;
      $display("Error at %0t: no pready on the register bus", $time);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  function automatic logic [2:0] lvl(input logic r, input logic d, input logic f);
    if (r)
      return d ? (f ? 3'h0 : 3'h1) : (f ? 3'h2 : 3'h5);
    return d ? (f ? 3'h1 : 3'h0) : (f ? 3'h3 : 3'h4);
  endfunction : lvl
  // settle point five cycles after the toggle, well inside a sixteen-cycle half
  task automatic wait_frame;
    logic f;
    int n;
    f = frame_phase;
    n = 0;
    while (frame_phase === f && n < 100)
    begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0, n < 100}, 32'h1);
    chk({31'h0, dma_req}, 32'h1);
    repeat (5) @(posedge pclk);
  endtask : wait_frame
  task t_reset;
    chk({30'h0, bias_config}, 32'h2);
    apb(1'b0, LPDLS_OFF_TIME, 32'h0);
    chk(rd, LPDLS_TIME_RST);
    apb(1'b0, 8'h1C, 32'h0);
    chk({31'h0, er}, 32'h1);
    apb(1'b1, 8'h02, 32'hFF);
    chk({31'h0, er}, 32'h1);
  endtask : t_reset
  task t_bias;
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, LPDLS_OFF_BIAS, 32'(i));
      repeat (2) @(posedge pclk);
      chk({30'h0, bias_config}, (i == 0) ? 32'h2 : ((i == 1) ? 32'h1 : 32'h0));
    end
  endtask : t_bias
  task automatic t_level;
    logic [7:0] cur;
    cur = 8'hCC;
    apb(1'b1, LPDLS_OFF_TIME, 32'h0002_000F);
    apb(1'b1, LPDLS_OFF_ROLE, 32'hF0);
    apb(1'b1, LPDLS_OFF_DATA, 32'hCC);
    apb(1'b1, LPDLS_OFF_DRV, 32'h9);
    for (int k = 0; k < 2; k++)
    begin
      wait_frame;
      chk({31'h0, frame_phase}, 32'(k == 0));
      for (int p = 0; p < 8; p++)
        chk({29'h0, elec_level[3*p+:3]}, {29'h0, lvl(p >= 4, cur[p], k == 0)});
      chk({16'h0, pin_buf_en, pin_bypass}, 32'h00FF);
      apb(1'b1, LPDLS_OFF_DATA, 32'h35);
      apb(1'b0, LPDLS_OFF_DISP, 32'h0);
      chk(rd, {24'h0, cur});
      cur = 8'h35;
    end
    apb(1'b1, LPDLS_OFF_DRV, 32'h1);
    wait_frame;
    chk({16'h0, elec_float, pin_bypass}, 32'hFF00);
  endtask : t_level
  task automatic t_mode;
    logic [31:0] dv;
    for (int i = 0; i < 4; i++)
    begin
      dv = 32'(16'h5731 >> (4*i)) & 32'hF;
      apb(1'b1, LPDLS_OFF_DRV, dv);
      wait_frame;
      // mixed cases are past the high time here, so upper mode bits read 11
      chk({8'h0, seg_s}, {8'h0, {8{3'(12'h700 >> (3*i))}}});
      chk({8'h0, com_s}, {8'h0, {8{3'(12'h708 >> (3*i))}}});
      apb(1'b0, LPDLS_OFF_STAT, 32'h0);
      chk({30'h0, rd[3:2]}, dv[2] ? 32'h3 : 32'h0);
      if (dv[2])
        chk({24'h0, pin_buf_en}, 32'hFF);
    end
  endtask : t_mode
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_bias;
    t_level;
    t_mode;
    end_sim;
  end
  initial
  begin
    #200000;
    err_total++;
    end_sim;
  end
endmodule : lcd_pin_drive_level_select_tb_top
